/* hw/cme_pkg.sv */
package cme_pkg;

   // Opcodes, one-byte forms sit in the low byte.
   localparam logic [15:0] OP_VERSION_QUERY  = 16'h3009;
   localparam logic [15:0] OP_IDLE_ONE       = 16'h0070;
   localparam logic [15:0] OP_IDLE_TWO       = 16'h0073;
   localparam logic [15:0] OP_IDLE_THREE     = 16'h0072;
   localparam logic [15:0] OP_UNION_BYTE_TWO = 16'h00B3;
   localparam logic [15:0] OP_UNION_HALF_TWO = 16'h00B2;
   localparam logic [15:0] OP_UNION_WORD_TWO = 16'h00B0;
   localparam logic [15:0] OP_UNION_BYTE_THR = 16'h00F3;
   localparam logic [15:0] OP_UNION_HALF_THR = 16'h00F2;
   localparam logic [15:0] OP_UNION_WORD_THR = 16'h00F0;
   localparam logic [15:0] OP_STACK_TAKE     = 16'h0020;
   localparam logic [15:0] OP_STACK_EA_STORE = 16'h00E0;
   localparam logic [15:0] OP_STACK_STORE    = 16'h00A0;
   localparam logic [15:0] OP_RET_CARRY_CLR  = 16'h0050;
   localparam logic [15:0] OP_RET_CARRY_SET  = 16'h0058;
   localparam logic [15:0] OP_RET_EQ_SIGNED  = 16'h007C;
   localparam logic [15:0] OP_RET_EQ_UNSIGN  = 16'h006C;
   localparam logic [15:0] OP_FRAME_RESTORE  = 16'h0018;

   // Fixed instruction lengths in bytes.
   localparam logic [3:0]  LEN_ONE   = 4'h1;
   localparam logic [3:0]  LEN_TWO   = 4'h2;
   localparam logic [3:0]  LEN_THREE = 4'h3;

   // Stack and frame geometry.
   localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
   localparam logic [31:0] FRAME_SP_OFS  = 32'h0000_001C;
   localparam logic [31:0] FRAME_REG_OFS = 32'h0000_0018;
   localparam logic [3:0]  LAST_SAVED_REG = 4'h8;
   localparam logic [3:0]  RESULT_REG     = 4'h0;

   // Condition flag positions inside the flag nibble.
   localparam int FLAG_N = 3;
   localparam int FLAG_Z = 2;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 0;

   // Register map, byte addresses.
   localparam logic [11:0] ADDR_CTRL       = 12'h000;
   localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h008;
   localparam logic [11:0] ADDR_STACK_PTR  = 12'h00C;
   localparam logic [11:0] ADDR_FRAME_PTR  = 12'h010;
   localparam logic [11:0] ADDR_PROG_CNT   = 12'h014;
   localparam logic [11:0] ADDR_FLAGS      = 12'h018;
   localparam logic [11:0] ADDR_VERSION    = 12'h01C;
   localparam logic [11:0] ADDR_REG_BASE   = 12'h040;
   localparam logic [11:0] ADDR_REG_END    = 12'h064;

   // Interrupt status bits.
   localparam int IRQ_W       = 3;
   localparam int IRQ_DONE    = 0;
   localparam int IRQ_ILLEGAL = 1;
   localparam int IRQ_UNKNOWN = 2;

   // Values after reset.
   localparam logic [31:0] SP_RESET = 32'h0000_0000;
   localparam logic [31:0] FP_RESET = 32'h0000_0000;
   localparam logic [31:0] PC_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_REGISTER  = 3'h0,
      MODE_LITERAL   = 3'h1,
      MODE_IMMEDIATE = 3'h2,
      MODE_EXPANDED  = 3'h3,
      MODE_MEMORY    = 3'h4
   } cme_mode_t;

   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;

   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_EXEC    = 7'h02,
      ST_POP_RD  = 7'h04,
      ST_PUSH_WR = 7'h08,
      ST_RET_RD  = 7'h10,
      ST_RST_FP  = 7'h20,
      ST_RST_REG = 7'h40
   } cme_state_t;

endpackage

/* hw/cme_rf_if.sv */
`timescale 1ns/1ps
interface cme_rf_if;
   logic        we;
   logic [3:0]  waddr;
   logic [31:0] wdata;
   logic [3:0]  raddr;
   logic [31:0] rdata;

   modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

/* hw/cme_regfile.sv */
`timescale 1ns/1ps
module cme_regfile (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Access port
   cme_rf_if.mem    rf
);
   typedef struct packed {
      logic [15:0][31:0] word;
      logic [31:0]       rdata;
   } cme_rf_q_t;

   cme_rf_q_t q;
   cme_rf_q_t next_q;

   always_comb begin
      next_q = q;
      next_q.rdata = q.word[rf.raddr];
      if (rf.we) begin
         next_q.word[rf.waddr] = rf.wdata;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign rf.rdata = q.rdata;
endmodule

/* hw/cme_exec.sv */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cme_exec #(
   // Arbitrary value, not tied to any real part.
   parameter logic [7:0] VERSION_NUMBER = 8'h01
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Instruction issue
   input  wire logic              insValid,
   output logic                   insReady,
   input  wire logic [15:0]       insOpcode,
   input  wire logic [3:0]        insLen,
   input  wire cme_pkg::cme_mode_t insSrcMode,
   input  wire cme_pkg::cme_mode_t insDstMode,
   input  wire logic [1:0]        insDstSize,
   input  wire logic [31:0]       insSrcA,
   input  wire logic [31:0]       insSrcB,
   input  wire logic [31:0]       insSrcAddr,
   input  wire logic [3:0]        insRegNum,
   // Completion
   output logic                   resValid,
   output logic      [31:0]       resData,
   output logic      [1:0]        resSize,
   output logic                   excValid,
   output logic                   doneValid,
   // Memory master
   output logic                   memReq,
   output logic                   memWrite,
   output logic      [31:0]       memAddr,
   output logic      [31:0]       memWdata,
   input  wire logic              memAck,
   input  wire logic [31:0]       memRdata,
   // Interrupt
   output logic                   irq
);
   import cme_pkg::*;

   typedef struct packed {
      cme_state_t       state;
      logic             ctrlEn;
      logic [IRQ_W-1:0] irqStatus;
      logic [IRQ_W-1:0] irqMask;
      logic             irq;
      logic [31:0]      sp;
      logic [31:0]      fp;
      logic [31:0]      pc;
      logic [3:0]       psw;
      logic [15:0]      opcode;
      logic [3:0]       len;
      logic             dstLitImm;
      logic             dstExp;
      logic             srcLitImm;
      logic             srcReg;
      logic             srcExp;
      logic [1:0]       dstSize;
      logic [31:0]      a;
      logic [31:0]      b;
      logic [31:0]      ea;
      logic [31:0]      tempa;
      logic [31:0]      tempb;
      logic [31:0]      tptr;
      logic [3:0]       rn;
      logic             insReady;
      logic             resValid;
      logic [31:0]      resData;
      logic [1:0]       resSize;
      logic             excValid;
      logic             doneValid;
      logic             memReq;
      logic             memWrite;
      logic [31:0]      memAddr;
      logic [31:0]      memWdata;
      logic             pready;
      logic             pslverr;
      logic [31:0]      prdata;
      logic             rfWe;
      logic [3:0]       rfWaddr;
      logic [31:0]      rfWdata;
   } cme_q_t;

   localparam cme_q_t Q_RESET = '{state: ST_IDLE, sp: SP_RESET, fp: FP_RESET,
                                  pc: PC_RESET, default: '0};

   cme_q_t   q;
   cme_q_t   next_q;
   cme_rf_if rf ();

   cme_regfile u_regfile (
      .clk (clk),
      .rst (rst),
      .rf  (rf.mem)
   );

   function automatic logic [31:0] fit(input logic [31:0] v, input logic [1:0] sz,
                                       input logic sgn);
      logic [31:0] r;
      r = v;
      if (sz == SIZE_BYTE) begin
         r = {{24{sgn & v[7]}}, v[7:0]};
      end else if (sz == SIZE_HALF) begin
         r = {{16{sgn & v[15]}}, v[15:0]};
      end
      return r;
   endfunction

   function automatic logic top_bit(input logic [31:0] v, input logic [1:0] sz);
      logic r;
      r = v[31];
      if (sz == SIZE_BYTE) begin
         r = v[7];
      end else if (sz == SIZE_HALF) begin
         r = v[15];
      end
      return r;
   endfunction

   // Register reads are addressed straight from the bus so that the
   // registered file output is valid in the first access cycle.
   assign rf.raddr = 4'(paddr[5:2] - ADDR_REG_BASE[5:2]);
   assign rf.we    = q.rfWe;
   assign rf.waddr = q.rfWaddr;
   assign rf.wdata = q.rfWdata;

   always_comb begin
      logic             evDone;
      logic             evIll;
      logic             evUnk;
      logic             take;
      logic             busWr;
      logic             regHit;
      logic [IRQ_W-1:0] clr;
      logic [31:0]      res;
      logic [31:0]      trunc;
      evDone = 1'b0;
      evIll  = 1'b0;
      evUnk  = 1'b0;
      take   = 1'b0;
      busWr  = psel & penable & q.pready & pwrite & ~q.pslverr;
      regHit = (paddr >= ADDR_REG_BASE) && (paddr < ADDR_REG_END) && (paddr[1:0] == 2'h0);
      clr    = '0;
      res    = q.a | q.b;
      trunc  = fit(res, q.dstSize, 1'b0);

      next_q = q;
      next_q.resValid  = 1'b0;
      next_q.excValid  = 1'b0;
      next_q.doneValid = 1'b0;
      next_q.rfWe      = 1'b0;

      // APB: one wait state, answer registered in the first access cycle.
      next_q.pready = psel & penable & ~q.pready;
      if (psel & penable & ~q.pready) begin
         next_q.pslverr = 1'b0;
         next_q.prdata  = 32'h0000_0000;
         unique case (paddr)
            ADDR_CTRL:       next_q.prdata = {31'h0000_0000, q.ctrlEn};
            ADDR_IRQ_STATUS: next_q.prdata = {29'h0000_0000, q.irqStatus};
            ADDR_IRQ_MASK:   next_q.prdata = {29'h0000_0000, q.irqMask};
            ADDR_STACK_PTR:  next_q.prdata = q.sp;
            ADDR_FRAME_PTR:  next_q.prdata = q.fp;
            ADDR_PROG_CNT:   next_q.prdata = q.pc;
            ADDR_FLAGS:      next_q.prdata = {28'h000_0000, q.psw};
            ADDR_VERSION:    next_q.prdata = fit({24'h00_0000, VERSION_NUMBER}, SIZE_BYTE, 1'b1);
            default: begin
               if (regHit) begin
                  next_q.prdata = rf.rdata;
               end else begin
                  next_q.pslverr = 1'b1;
               end
            end
         endcase
      end
      if (busWr) begin
         unique case (paddr)
            ADDR_CTRL:       next_q.ctrlEn = pwdata[0];
            ADDR_IRQ_STATUS: clr = pwdata[IRQ_W-1:0];
            ADDR_IRQ_MASK:   next_q.irqMask = pwdata[IRQ_W-1:0];
            default: begin
               // Architectural state may only be loaded while nothing runs.
               if (q.state == ST_IDLE) begin
                  if (paddr == ADDR_STACK_PTR) next_q.sp = pwdata;
                  if (paddr == ADDR_FRAME_PTR) next_q.fp = pwdata;
                  if (paddr == ADDR_PROG_CNT) next_q.pc = pwdata;
                  if (paddr == ADDR_FLAGS) next_q.psw = pwdata[3:0];
               end
            end
         endcase
      end

      unique case (q.state)
         ST_IDLE: begin
            if (insValid & q.insReady) begin
               next_q.opcode    = insOpcode;
               next_q.len       = insLen;
               next_q.dstLitImm = (insDstMode == MODE_LITERAL) || (insDstMode == MODE_IMMEDIATE);
               next_q.dstExp    = insDstMode == MODE_EXPANDED;
               next_q.srcLitImm = (insSrcMode == MODE_LITERAL) || (insSrcMode == MODE_IMMEDIATE);
               next_q.srcReg    = insSrcMode == MODE_REGISTER;
               next_q.srcExp    = insSrcMode == MODE_EXPANDED;
               next_q.dstSize   = insDstSize;
               next_q.a         = insSrcA;
               next_q.b         = insSrcB;
               next_q.ea        = insSrcAddr;
               next_q.rn        = insRegNum;
               next_q.state     = ST_EXEC;
            end
         end
         ST_EXEC: begin
            unique case (q.opcode)
               OP_VERSION_QUERY: begin
                  next_q.rfWe    = 1'b1;
                  next_q.rfWaddr = RESULT_REG;
                  next_q.rfWdata = fit({24'h00_0000, VERSION_NUMBER}, SIZE_BYTE, 1'b1);
                  next_q.pc      = q.pc + 32'(LEN_TWO);
                  evDone         = 1'b1;
               end
               OP_IDLE_ONE: begin
                  next_q.pc = q.pc + 32'(LEN_ONE);
                  evDone    = 1'b1;
               end
               OP_IDLE_TWO: begin
                  next_q.pc = q.pc + 32'(LEN_TWO);
                  evDone    = 1'b1;
               end
               OP_IDLE_THREE: begin
                  next_q.pc = q.pc + 32'(LEN_THREE);
                  evDone    = 1'b1;
               end
               OP_UNION_BYTE_TWO, OP_UNION_HALF_TWO, OP_UNION_WORD_TWO,
               OP_UNION_BYTE_THR, OP_UNION_HALF_THR, OP_UNION_WORD_THR: begin
                  if (q.dstLitImm) begin
                     evIll = 1'b1;
                  end else begin
                     next_q.resValid     = 1'b1;
                     next_q.resData      = trunc;
                     next_q.resSize      = q.dstSize;
                     next_q.psw[FLAG_N]  = top_bit(trunc, q.dstSize);
                     next_q.psw[FLAG_Z]  = trunc == 32'h0000_0000;
                     next_q.psw[FLAG_C]  = 1'b0;
                     next_q.psw[FLAG_V]  = (res != trunc) &&
                                           (res != fit(res, q.dstSize, 1'b1));
                     next_q.pc           = q.pc + 32'(q.len);
                     evDone              = 1'b1;
                  end
               end
               OP_STACK_TAKE: begin
                  if (q.dstLitImm | q.dstExp) begin
                     evIll = 1'b1;
                  end else begin
                     next_q.sp       = q.sp - WORD_BYTES;
                     next_q.memReq   = 1'b1;
                     next_q.memWrite = 1'b0;
                     next_q.memAddr  = q.sp - WORD_BYTES;
                     next_q.state    = ST_POP_RD;
                  end
               end
               OP_STACK_EA_STORE: begin
                  if (q.srcLitImm | q.srcReg | q.srcExp) begin
                     evIll = 1'b1;
                  end else begin
                     next_q.memReq   = 1'b1;
                     next_q.memWrite = 1'b1;
                     next_q.memAddr  = q.sp;
                     next_q.memWdata = q.ea;
                     next_q.psw      = {q.ea[31], q.a == 32'h0000_0000, 2'b00};
                     next_q.state    = ST_PUSH_WR;
                  end
               end
               OP_STACK_STORE: begin
                  if (q.srcExp) begin
                     evIll = 1'b1;
                  end else begin
                     next_q.memReq   = 1'b1;
                     next_q.memWrite = 1'b1;
                     next_q.memAddr  = q.sp;
                     next_q.memWdata = q.a;
                     next_q.psw      = {q.a[31], q.a == 32'h0000_0000, 2'b00};
                     next_q.state    = ST_PUSH_WR;
                  end
               end
               OP_RET_CARRY_CLR, OP_RET_CARRY_SET, OP_RET_EQ_SIGNED, OP_RET_EQ_UNSIGN: begin
                  if (q.opcode == OP_RET_CARRY_CLR) take = ~q.psw[FLAG_C];
                  if (q.opcode == OP_RET_CARRY_SET) take = q.psw[FLAG_C];
                  if (q.opcode == OP_RET_EQ_SIGNED) take = q.psw[FLAG_Z];
                  if (q.opcode == OP_RET_EQ_UNSIGN) take = q.psw[FLAG_Z];
                  if (take) begin
                     next_q.sp       = q.sp - WORD_BYTES;
                     next_q.memReq   = 1'b1;
                     next_q.memWrite = 1'b0;
                     next_q.memAddr  = q.sp - WORD_BYTES;
                     next_q.state    = ST_RET_RD;
                  end else begin
                     next_q.pc = q.pc + 32'(LEN_ONE);
                     evDone    = 1'b1;
                  end
               end
               OP_FRAME_RESTORE: begin
                  if (q.srcExp) begin
                     evIll = 1'b1;
                  end else begin
                     next_q.tempa    = q.fp - FRAME_SP_OFS;
                     next_q.tptr     = q.fp - FRAME_REG_OFS;
                     next_q.memReq   = 1'b1;
                     next_q.memWrite = 1'b0;
                     next_q.memAddr  = q.fp - FRAME_SP_OFS;
                     next_q.state    = ST_RST_FP;
                  end
               end
               default: begin
                  evUnk = 1'b1;
               end
            endcase
            if (evDone | evIll | evUnk) begin
               next_q.state = ST_IDLE;
            end
         end
         ST_POP_RD: begin
            if (memAck) begin
               next_q.memReq   = 1'b0;
               next_q.resValid = 1'b1;
               next_q.resData  = memRdata;
               next_q.resSize  = SIZE_WORD;
               next_q.psw      = {memRdata[31], memRdata == 32'h0000_0000, 2'b00};
               next_q.pc       = q.pc + 32'(q.len);
               next_q.state    = ST_IDLE;
               evDone          = 1'b1;
            end
         end
         ST_PUSH_WR: begin
            if (memAck) begin
               next_q.memReq = 1'b0;
               next_q.sp     = q.sp + WORD_BYTES;
               next_q.pc     = q.pc + 32'(q.len);
               next_q.state  = ST_IDLE;
               evDone        = 1'b1;
            end
         end
         ST_RET_RD: begin
            if (memAck) begin
               next_q.memReq = 1'b0;
               next_q.pc     = memRdata;
               next_q.state  = ST_IDLE;
               evDone        = 1'b1;
            end
         end
         ST_RST_FP: begin
            if (memAck) begin
               next_q.tempb = memRdata;
               if (q.rn <= LAST_SAVED_REG) begin
                  next_q.memAddr = q.tptr;
                  next_q.state   = ST_RST_REG;
               end else begin
                  next_q.memReq = 1'b0;
                  next_q.fp     = memRdata;
                  next_q.sp     = q.tempa;
                  next_q.pc     = q.pc + 32'(q.len);
                  next_q.state  = ST_IDLE;
                  evDone        = 1'b1;
               end
            end
         end
         ST_RST_REG: begin
            if (memAck) begin
               next_q.rfWe    = 1'b1;
               next_q.rfWaddr = q.rn;
               next_q.rfWdata = memRdata;
               next_q.rn      = q.rn + 4'h1;
               next_q.tptr    = q.tptr + WORD_BYTES;
               next_q.memAddr = q.tptr + WORD_BYTES;
               if (q.rn == LAST_SAVED_REG) begin
                  next_q.memReq = 1'b0;
                  next_q.fp     = q.tempb;
                  next_q.sp     = q.tempa;
                  next_q.pc     = q.pc + 32'(q.len);
                  next_q.state  = ST_IDLE;
                  evDone        = 1'b1;
               end
            end
         end
      endcase

      next_q.excValid  = evIll | evUnk;
      next_q.doneValid = evDone;
      // A new event wins over a clear written in the same cycle.
      next_q.irqStatus = (q.irqStatus & ~clr) | {evUnk, evIll, evDone};
      next_q.irq       = |(next_q.irqStatus & next_q.irqMask);
      next_q.insReady  = (next_q.state == ST_IDLE) & next_q.ctrlEn;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= Q_RESET;
      end else begin
         q <= next_q;
      end
   end

   assign prdata    = q.prdata;
   assign pready    = q.pready;
   assign pslverr   = q.pslverr;
   assign insReady  = q.insReady;
   assign resValid  = q.resValid;
   assign resData   = q.resData;
   assign resSize   = q.resSize;
   assign excValid  = q.excValid;
   assign doneValid = q.doneValid;
   assign memReq    = q.memReq;
   assign memWrite  = q.memWrite;
   assign memAddr   = q.memAddr;
   assign memWdata  = q.memWdata;
   assign irq       = q.irq;
endmodule

/* test/cme_mem_model.sv */
`timescale 1ns/1ps
module cme_mem_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        memReq,
   input  wire logic        memWrite,
   input  wire logic [31:0] memAddr,
   input  wire logic [31:0] memWdata,
   output logic             memAck,
   output logic [31:0]      memRdata
);
   logic [31:0] mem [16];
   logic        stall;
   // Outside an answer the data lines show junk: the last word inverted, then the last word again, alternating each cycle.
   always @(posedge clk) begin
      stall <= slow && !stall;
      memAck <= memReq && !memAck && !stall;
      memRdata <= (memReq && !memAck && !stall) ? mem[memAddr[5:2]] : ~memRdata;
      if (memReq && !memAck && !stall && memWrite) mem[memAddr[5:2]] <= memWdata;
   end
endmodule

/* test/cme_exec_checker.sv */
`timescale 1ns/1ps
module cme_exec_checker
   import cme_pkg::*;
(
   input wire logic        clk, rst, psel, penable, pready, insValid, insReady,
   input wire logic        resValid, excValid, doneValid, memReq, memAck, memWrite,
   input wire logic [15:0] insOpcode,
   input wire cme_mode_t   insSrcMode, insDstMode,
   input wire logic [31:0] memAddr
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wire acc = insValid && insReady;
   wire uni = insOpcode[15:4] inside {12'h00B, 12'h00F} && insOpcode[3:0] inside {0, 2, 3};
   wire idl = insOpcode inside {OP_IDLE_ONE, OP_IDLE_TWO, OP_IDLE_THREE, OP_VERSION_QUERY};
   chk_apb_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
   chk_apb_pulse: assert property (pready |=> !pready) else $error("long ready");
   chk_busy_hold: assert property (acc |=> !insReady ##1 (!insReady || doneValid || excValid))
      else $error("ready early");
   chk_idle_retire:
      assert property (acc && idl |-> ##2 doneValid && !excValid && !resValid) else $error("idle");
   chk_union_bad:
      assert property (acc && uni && insDstMode inside {MODE_LITERAL, MODE_IMMEDIATE}
         |-> ##2 excValid && !resValid) else $error("union dst");
   chk_union_res:
      assert property (acc && uni && insDstMode == MODE_REGISTER |-> ##2 resValid && doneValid)
         else $error("union res");
   chk_take_read:
      assert property (acc && insOpcode == OP_STACK_TAKE && insDstMode == MODE_REGISTER
         |-> ##2 memReq && !memWrite) else $error("take read");
   chk_store_write:
      assert property (acc && insOpcode[7:0] inside {8'hA0, 8'hE0} && insSrcMode == MODE_MEMORY
         |-> ##2 memReq && memWrite) else $error("store write");
   chk_write_done:
      assert property (memReq && memAck && memWrite |=> doneValid && !memReq) else $error("wr");
   chk_mem_hold: assert property (memReq && !memAck |=> memReq && $stable(memAddr))
      else $error("mem hold");
   cover property (acc && uni);
   cover property (excValid);
   cover property (memReq && memAck && !memWrite);
endmodule
bind cme_exec cme_exec_checker chk (.*);

/* test/cpu_misc_instr_exec_tb_top.sv */
`timescale 1ns/1ps
module cpu_misc_instr_exec_tb_top;
   import cme_pkg::*;
   typedef struct packed {
      logic [15:0] o;
      logic [3:0]  l;
      logic [1:0]  z;
      cme_mode_t   d;
      logic [31:0] a, b, r;
      logic        e;
      logic [3:0]  f;
   } cme_row_t;
   localparam cme_mode_t RG = MODE_REGISTER, LT = MODE_LITERAL, IM = MODE_IMMEDIATE;
   localparam cme_mode_t EX = MODE_EXPANDED, ME = MODE_MEMORY;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, insValid = 0, slow = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, insSrcA = 0, insSrcB = 0, insSrcAddr = 0, rd, pc = 0;
   logic [15:0] insOpcode = 0;
   logic [3:0]  insLen = 0, insRegNum = 0, rf [4] = '{0, 2, 4, 4};
   logic [1:0]  insDstSize = 0, sz;
   cme_mode_t   insSrcMode = RG, insDstMode = RG;
   logic        er, gotRes, gotExc;
   int          err_count = 0, check_count = 0, cyc = 0;
   wire         pready, pslverr, insReady, resValid, excValid, doneValid, memReq, memWrite;
   wire         memAck, irq;
   wire [31:0]  prdata, resData, memAddr, memWdata, memRdata;
   wire [1:0]   resSize;
   cme_row_t    rows [11] = '{
      '{16'hB0, 3, 2, RG, 32'hF0, 32'h8000_000F, 32'h8000_00FF, 0, 8},
      '{16'hB3, 3, 0, RG, 32'h100, 1, 1, 0, 1}, '{16'hF2, 4, 1, RG, 0, 0, 0, 0, 4},
      '{16'hF2, 4, 1, LT, 0, 0, 0, 1, 4}, '{16'hF3, 4, 0, RG, 32'h80, 0, 32'h80, 0, 8},
      '{16'hB2, 3, 1, IM, 0, 0, 0, 1, 8}, '{16'hF0, 4, 2, IM, 0, 0, 0, 1, 8},
      '{16'h70, 1, 0, RG, 0, 0, 0, 0, 8}, '{16'h73, 2, 0, RG, 0, 0, 0, 0, 8},
      '{16'h72, 3, 0, RG, 0, 0, 0, 0, 8}, '{16'h3009, 2, 0, RG, 0, 0, 0, 0, 8}};
   always #5 clk = ~clk;
   cme_exec #(.VERSION_NUMBER(8'h85)) uut (.*);
   cme_mem_model mem (.*);
   task automatic chk(input logic ok);
      check_count++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("ERROR %0t value mismatch", $time);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, ad, wd};
      @(posedge clk) penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'b00;
   endtask
   task automatic rchk(input logic [11:0] ad, input logic [31:0] ex);
      apb(0, ad, 0);
      chk(rd === ex);
   endtask
   task automatic run(input logic [15:0] o, input logic [3:0] l, input cme_mode_t s, d);
      @(posedge clk);
      {insOpcode, insLen, insValid} <= {o, l, 1'b1};
      insSrcMode <= s;
      insDstMode <= d;
      do @(posedge clk); while (insReady !== 1'b1);
      insValid <= 0;
      gotRes = 0;
      do begin
         @(posedge clk);
         if (resValid === 1'b1) {gotRes, rd, sz} = {1'b1, resData, resSize};
      end while (doneValid !== 1'b1 && excValid !== 1'b1);
      gotExc = excValid;
   endtask
   task automatic final_report;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         final_report;
      end
   end
   initial begin
      repeat (10) @(posedge clk);
      chk(insReady === 0 && pready === 0);
      rst <= 0;
      apb(1, ADDR_CTRL, 1);
      foreach (rows[i]) begin
         {insDstSize, insSrcA, insSrcB} <= {rows[i].z, rows[i].a, rows[i].b};
         run(rows[i].o, rows[i].l, RG, rows[i].d);
         chk(gotExc === rows[i].e);
         chk(gotRes === (!rows[i].e && rows[i].o[7:4] inside {4'hB, 4'hF}));
         chk(!gotRes || (rd === rows[i].r && sz === rows[i].z));
         pc = rows[i].e ? pc : pc + rows[i].l;
         rchk(ADDR_FLAGS, {28'h0, rows[i].f});
         rchk(ADDR_PROG_CNT, pc);
      end
      rchk(ADDR_REG_BASE, 32'hFFFF_FF85);
      apb(0, 12'hFFC, 0);
      chk(er === 1);
      slow <= 1;
      apb(1, ADDR_STACK_PTR, 32'h10);
      insSrcA <= 0;
      run(OP_STACK_STORE, 1, RG, RG);
      insSrcAddr <= 32'h8000_0020;
      run(OP_STACK_EA_STORE, 2, ME, RG);
      rchk(ADDR_FLAGS, 32'hC);
      run(OP_STACK_TAKE, 2, RG, RG);
      chk(rd === 32'h8000_0020);
      run(OP_STACK_TAKE, 2, RG, RG);
      chk(rd === 0);
      rchk(ADDR_FLAGS, 4);
      rchk(ADDR_STACK_PTR, 32'h10);
      run(OP_STACK_EA_STORE, 2, RG, RG);
      chk(gotExc === 1);
      run(OP_STACK_STORE, 2, EX, RG);
      chk(gotExc === 1);
      for (int i = 0; i < 4; i++) begin
         insSrcA <= 32'h100 + i;
         run(OP_STACK_STORE, 1, RG, RG);
         apb(1, ADDR_FLAGS, {28'h0, ~rf[i]});
         run(i < 2 ? 16'h50 + 8 * i : 16'h7C - 16 * (i - 2), 1, RG, RG);
         rchk(ADDR_STACK_PTR, 32'h14);
         apb(1, ADDR_FLAGS, {28'h0, rf[i]});
         run(i < 2 ? 16'h50 + 8 * i : 16'h7C - 16 * (i - 2), 1, RG, RG);
         rchk(ADDR_PROG_CNT, 32'h100 + i);
         rchk(ADDR_FLAGS, {28'h0, rf[i]});
      end
      apb(1, ADDR_STACK_PTR, 32'h24);
      for (int j = 0; j < 7; j++) begin
         insSrcA <= (j == 0) ? 32'h30 : 32'h8000_0010 + j;
         run(OP_STACK_STORE, 1, RG, RG);
      end
      apb(1, ADDR_FRAME_PTR, 32'h40);
      insRegNum <= 3;
      run(OP_FRAME_RESTORE, 2, RG, RG);
      rchk(ADDR_STACK_PTR, 32'h24);
      rchk(ADDR_FRAME_PTR, 32'h30);
      rchk(ADDR_REG_BASE + 12'h20, 32'h8000_0016);
      rchk(ADDR_FLAGS, 8);
      run(OP_FRAME_RESTORE, 2, EX, EX);
      chk(gotExc === 1);
      run(16'h00FF, 1, RG, RG);
      chk(irq === 0);
      apb(1, ADDR_IRQ_MASK, 32'h4);
      repeat (2) @(posedge clk);
      chk(irq === 1);
      apb(1, ADDR_IRQ_STATUS, 32'h7);
      repeat (2) @(posedge clk);
      chk(irq === 0);
      rst <= 1;
      @(posedge clk) rst <= 0;
      rchk(ADDR_STACK_PTR, 0);
      final_report;
   end
endmodule
